// File: rtl/ssfl_defines.vh
// register map, field positions, reset values and counts of the serial status block
`ifndef SSFL_DEFINES_VH
`define SSFL_DEFINES_VH
`define SSFL_OFS_STATUS   4'h0
`define SSFL_OFS_DATA     4'h4
`define SSFL_OFS_CONTROL  4'h8
`define SSFL_OFS_DIVISOR  4'hC
`define SSFL_ST_TX_BUFFER_EMPTY_FLAG      7
`define SSFL_ST_TC        6
`define SSFL_ST_RX_BUFFER_FULL_FLAG      5
`define SSFL_ST_IDLE      4
`define SSFL_ST_OVR       3
`define SSFL_ST_NF        2
`define SSFL_ST_FE        1
`define SSFL_ST_PF        0
`define SSFL_CT_PAR_ODD   7
`define SSFL_CT_PAR_EN    6
`define SSFL_CT_ILT       5
`define SSFL_CT_CHAR9     4
`define SSFL_CT_TE        3
`define SSFL_CT_SBK       0
`define SSFL_CTRL_RESET   8'h00
`define SSFL_DIV_RESET    13'h0001
`define SSFL_STATUS_RESET 8'hC0
`define SSFL_KIND_DATA    2'h0
`define SSFL_KIND_PRE     2'h1
`define SSFL_KIND_BRK     2'h2
`define SSFL_BITS_SHORT   4'hA
`define SSFL_BITS_LONG    4'hB
`define SSFL_IDLE_SHORT   8'hA0
`define SSFL_IDLE_LONG    8'hB0
`endif

// File: rtl/ssfl_rx.v
// receive shifter with majority sampling and noise, framing and parity checks
`timescale 1ns/100ps
`include "ssfl_defines.vh"
module ssfl_rx (
  input  wire       sys_clk,
  input  wire       reset,
  input  wire       tick,
  input  wire       rxd,
  input  wire       char9,
  input  wire       par_en,
  input  wire       par_odd,
  output reg        ready,    // one-cycle pulse, character complete
  output reg  [8:0] data,
  output reg        noise,
  output reg        ferr,
  output reg        perr,
  output reg        busy
);
  reg  [3:0] phase;   // tick within bit
  reg  [3:0] bitn;    // 0 start, then data, then stop
  reg  [2:0] ones;    // high samples in this bit
  reg  [2:0] n;       // samples in this bit
  wire       in_start = (bitn == 4'h0);
  wire       samp = in_start ? (phase >= 4'h4 && phase <= 4'hA) : (phase >= 4'h7 && phase <= 4'h9);
  wire [2:0] ones_f = ones + {2'b00, samp & rxd};
  wire [2:0] n_f = n + {2'b00, samp};
  wire       maj = ({ones_f, 1'b0} > {1'b0, n_f});
  wire       dis = (ones_f != 3'h0) && (ones_f != n_f);
  wire [3:0] stopn = char9 ? 4'hA : 4'h9;
  wire       parity_bad = char9 ? (^data[7:0] ^ par_odd) != data[8] : (^data[6:0] ^ par_odd) != data[7];
  // start on a low sample, vote each bit at its last tick
  always @(posedge sys_clk) begin
    ready <= 1'b0;
    if (reset) begin
      phase <= 4'h0;
      bitn  <= 4'h0;
      ones  <= 3'h0;
      n     <= 3'h0;
      data  <= 9'h000;
      noise <= 1'b0;
      ferr  <= 1'b0;
      perr  <= 1'b0;
      busy  <= 1'b0;
    end else if (tick) begin
      if (!busy) begin
        if (!rxd) begin
          busy  <= 1'b1;
          phase <= 4'h1;
          bitn  <= 4'h0;
          ones  <= 3'h0;
          n     <= 3'h0;
          noise <= 1'b0;
        end
      end else begin
        phase <= phase + 4'h1;
        ones  <= ones_f;
        n     <= n_f;
        if (phase == 4'hF) begin
          ones  <= 3'h0;
          n     <= 3'h0;
          noise <= noise | dis;
          bitn  <= bitn + 4'h1;
          if (in_start && maj) begin
            busy <= 1'b0;       // false start, glitch only
          end else if (bitn == stopn) begin
            ferr  <= ~maj;
            perr  <= par_en & parity_bad;
            ready <= 1'b1;
            busy  <= 1'b0;
          end else if (!in_start) begin
            data <= char9 ? {maj, data[8:1]} : {1'b0, maj, data[7:1]};
          end
        end
      end
    end
  end
endmodule // ssfl_rx

// File: rtl/ssfl_top.v
// serial port status flags with avalon-mm register access, receiver and transmitter
//
// Overview of operation
// - buffer-empty sets at reset and buffer-to-shifter move
// - buffer-empty clears: armed status read, data write
// - complete sets at reset and when fully idle
// - complete clears: armed read, then write/enable/break
// - buffer-full sets when character enters data register
// - buffer-full clears: armed status read, data read
// - idle sets after one idle character time
// - idle-type select chooses where idle counting starts
// - idle clears by read pair; rearms after character
// - idle sets only once per idle period
// - overrun sets on unread data; new character dropped
// - overrun clears: armed status read, data read
// - majority samples; disagreement sets noise with full
// - noise clears: status read, then data read
// - framing error when stop bit samples low
// - framing error clears: armed read, data read
// - parity error on mismatch when parity enabled
// - parity error clears: status read, data read
// - status register read-only; writes change nothing
`timescale 1ns/100ps
`include "ssfl_defines.vh"
module ssfl_top (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        rxd,
  output wire        txd
);

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  // request seen: waitrequest drops for exactly one cycle
  wire        rd_go;        // read taken, read data latched now
  wire        wr_go;        // write completes now
  wire        status_rd;    // status read, arms clears
  wire        data_rd;      // data read, completes rx clears
  wire        data_wr;      // data write, completes tx clears
  wire        ctrl_wr;      // control write
  wire        div_wr;       // divisor write

  // read side effects act at the edge that latches read data,
  // so the armed value equals the value software receives
  assign rd_go     = avs_read & avs_waitrequest;
  assign wr_go     = avs_write & ~avs_waitrequest;
  assign status_rd = rd_go & (avs_address == `SSFL_OFS_STATUS);
  assign data_rd   = rd_go & (avs_address == `SSFL_OFS_DATA);
  assign data_wr   = wr_go & (avs_address == `SSFL_OFS_DATA);
  assign ctrl_wr   = wr_go & (avs_address == `SSFL_OFS_CONTROL);
  assign div_wr    = wr_go & (avs_address == `SSFL_OFS_DIVISOR);

  // waitrequest: high at rest, low one cycle per request
  always @(posedge sys_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // control and divisor registers
  // ------------------------------------------------------------
  reg  [7:0]  ctrl;         // parity, idle type, length, enable, break
  reg  [12:0] divisor;      // sys_clk cycles per oversample tick, minus one
  wire        te      = ctrl[`SSFL_CT_TE];
  wire        char9   = ctrl[`SSFL_CT_CHAR9];
  wire        idle_type_select     = ctrl[`SSFL_CT_ILT];
  wire        par_en  = ctrl[`SSFL_CT_PAR_EN];
  wire        par_odd = ctrl[`SSFL_CT_PAR_ODD];
  wire        te_rise;      // enable written from 0 to 1
  wire        sbk_wr1;      // break bit written as 1

  assign te_rise = ctrl_wr & ~te & avs_writedata[`SSFL_CT_TE];
  assign sbk_wr1 = ctrl_wr & avs_writedata[`SSFL_CT_SBK];

  // plain storage, no side effects beyond the decode above
  always @(posedge sys_clk) begin
    if (reset) begin
      ctrl    <= `SSFL_CTRL_RESET;
      divisor <= `SSFL_DIV_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl <= avs_writedata[7:0];
      end
      if (div_wr) begin
        divisor <= avs_writedata[12:0];
      end
    end
  end

  // ------------------------------------------------------------
  // oversample tick
  // ------------------------------------------------------------
  reg  [12:0] div_cnt;      // counts up to divisor
  reg         tick;         // one pulse per oversample period

  // divisor zero gives a tick every cycle, handy in simulation
  always @(posedge sys_clk) begin
    if (reset) begin
      div_cnt <= 13'h0000;
      tick    <= 1'b0;
    end else if (div_cnt >= divisor) begin
      div_cnt <= 13'h0000;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 13'h0001;
      tick    <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // flags and clear arming
  // ------------------------------------------------------------
  reg         tx_buffer_empty_flag;         // transmit buffer empty
  reg         tc;           // transmission complete
  reg         rx_buffer_full_flag;         // receive buffer full
  reg         idle;         // idle line seen
  reg         ovr;          // receive overrun
  reg         nf;           // noise
  reg         fe;           // framing error
  reg         pf;           // parity error
  reg  [7:0]  arm;          // flag was 1 at the last status read
  wire [7:0]  flags = {tx_buffer_empty_flag, tc, rx_buffer_full_flag, idle, ovr, nf, fe, pf};

  // per-flag clear strobes, each needs its own armed bit
  wire clr_tx_buffer_empty_flag = data_wr & arm[`SSFL_ST_TX_BUFFER_EMPTY_FLAG];
  wire clr_tc   = (data_wr | te_rise | sbk_wr1) & arm[`SSFL_ST_TC];
  wire clr_rx_buffer_full_flag = data_rd & arm[`SSFL_ST_RX_BUFFER_FULL_FLAG];
  wire clr_idle = data_rd & arm[`SSFL_ST_IDLE];
  wire clr_ovr  = data_rd & arm[`SSFL_ST_OVR];
  wire clr_nf   = data_rd & arm[`SSFL_ST_NF];
  wire clr_fe   = data_rd & arm[`SSFL_ST_FE];
  wire clr_pf   = data_rd & arm[`SSFL_ST_PF];

  // arm captures the flags as read; a later set is not armed
  always @(posedge sys_clk) begin
    if (reset) begin
      arm <= 8'h00;
    end else if (status_rd) begin
      arm <= flags;
    end else begin
      // a data access consumes the arming of the flags it serves
      if (data_wr) begin
        arm[`SSFL_ST_TX_BUFFER_EMPTY_FLAG] <= 1'b0;
      end
      if (data_wr | te_rise | sbk_wr1) begin
        arm[`SSFL_ST_TC] <= 1'b0;
      end
      if (data_rd) begin
        arm[5:0] <= 6'h00;
      end
    end
  end

  // ------------------------------------------------------------
  // receiver and receive data register
  // ------------------------------------------------------------
  wire        rx_ready;     // character complete in shifter
  wire [8:0]  rx_data;
  wire        rx_noise;
  wire        rx_ferr;
  wire        rx_perr;
  wire        rx_busy;      // frame in progress
  reg  [8:0]  rx_buf;       // receive data register
  wire        rx_room  = ~rx_buffer_full_flag | clr_rx_buffer_full_flag;   // buffer free this edge
  wire        rx_take  = rx_ready & rx_room;
  wire        rx_lost  = rx_ready & ~rx_room;

  ssfl_rx u_rx (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (tick),
    .rxd     (rxd),
    .char9   (char9),
    .par_en  (par_en),
    .par_odd (par_odd),
    .ready   (rx_ready),
    .data    (rx_data),
    .noise   (rx_noise),
    .ferr    (rx_ferr),
    .perr    (rx_perr),
    .busy    (rx_busy)
  );

  // set wins over clear on every receive flag
  always @(posedge sys_clk) begin
    if (reset) begin
      rx_buffer_full_flag   <= 1'b0;
      ovr    <= 1'b0;
      nf     <= 1'b0;
      fe     <= 1'b0;
      pf     <= 1'b0;
      rx_buf <= 9'h000;
    end else begin
      rx_buffer_full_flag <= rx_take | (rx_buffer_full_flag & ~clr_rx_buffer_full_flag);
      // overrun keeps the old character and drops the new one's errors
      ovr  <= rx_lost | (ovr & ~clr_ovr);
      nf   <= (rx_take & rx_noise) | (nf & ~clr_nf);
      fe   <= (rx_take & rx_ferr) | (fe & ~clr_fe);
      pf   <= (rx_take & rx_perr) | (pf & ~clr_pf);
      if (rx_take) begin
        rx_buf <= rx_data;
      end
    end
  end

  // ------------------------------------------------------------
  // idle line detection
  // ------------------------------------------------------------
  reg  [7:0]  idle_cnt;     // oversample ticks of high line
  reg         idle_allow;   // a character arrived since last idle
  wire [7:0]  idle_need = char9 ? `SSFL_IDLE_LONG : `SSFL_IDLE_SHORT;
  // with the late type the frame itself never counts
  wire        idle_hold = ~rxd | (idle_type_select & rx_busy);
  wire        idle_hit  = tick & ~idle_hold & (idle_cnt == idle_need - 8'h01);

  // counter saturates so a long idle gives one event only
  always @(posedge sys_clk) begin
    if (reset) begin
      idle_cnt <= 8'h00;
    end else if (tick) begin
      if (idle_hold) begin
        idle_cnt <= 8'h00;
      end else if (idle_cnt != idle_need) begin
        idle_cnt <= idle_cnt + 8'h01;
      end
    end
  end

  // allow rearms only on a newly stored character
  always @(posedge sys_clk) begin
    if (reset) begin
      idle       <= 1'b0;
      idle_allow <= 1'b0;
    end else begin
      idle <= (idle_hit & idle_allow) | (idle & ~clr_idle);
      if (rx_take) begin
        idle_allow <= 1'b1;
      end else if (idle_hit) begin
        idle_allow <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // transmit buffer, queued preamble and break
  // ------------------------------------------------------------
  reg  [7:0]  tx_buf;       // transmit data buffer
  reg         tx_full;      // buffer holds an unsent character
  reg         pre_pend;     // preamble queued by enable rising
  reg         brk_pend;     // break queued by break bit
  wire        tx_busy;
  wire        tx_start = te & ~tx_busy & (brk_pend | pre_pend | tx_full);
  // break first, then preamble, then data
  wire [1:0]  tx_kind  = brk_pend ? `SSFL_KIND_BRK : (pre_pend ? `SSFL_KIND_PRE : `SSFL_KIND_DATA);
  wire        tx_move  = tx_start & (tx_kind == `SSFL_KIND_DATA);
  wire        brk_done;     // break finished, break bit still set
  reg         tx_busy_q;
  reg         tx_kind_brk;  // shifter currently sends a break

  ssfl_tx u_tx (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (tick),
    .start   (tx_start),
    .kind    (tx_kind),
    .data    (tx_buf),
    .char9   (char9),
    .par_en  (par_en),
    .par_odd (par_odd),
    .txd     (txd),
    .busy    (tx_busy)
  );

  assign brk_done = tx_busy_q & ~tx_busy & tx_kind_brk & ctrl[`SSFL_CT_SBK];

  // queue bookkeeping; a write while full overwrites the buffer
  always @(posedge sys_clk) begin
    if (reset) begin
      tx_buf      <= 8'h00;
      tx_full     <= 1'b0;
      pre_pend    <= 1'b0;
      brk_pend    <= 1'b0;
      tx_busy_q   <= 1'b0;
      tx_kind_brk <= 1'b0;
    end else begin
      tx_busy_q <= tx_busy;
      if (tx_start) begin
        tx_kind_brk <= (tx_kind == `SSFL_KIND_BRK);
      end
      if (data_wr) begin
        tx_buf  <= avs_writedata[7:0];
        tx_full <= 1'b1;
      end else if (tx_move) begin
        tx_full <= 1'b0;
      end
      if (te_rise) begin
        pre_pend <= 1'b1;
      end else if (tx_start & (tx_kind == `SSFL_KIND_PRE)) begin
        pre_pend <= 1'b0;
      end
      // further breaks follow while the break bit stays 1
      if (sbk_wr1 | brk_done) begin
        brk_pend <= 1'b1;
      end else if (tx_start & (tx_kind == `SSFL_KIND_BRK)) begin
        brk_pend <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // transmit flags
  // ------------------------------------------------------------
  // complete condition is masked in the cycle new work is queued,
  // otherwise the clear would be undone by the still-idle shifter
  wire tx_quiet = ~tx_full & ~tx_busy & ~tx_start & ~pre_pend & ~brk_pend;
  wire tc_set   = tx_quiet & ~data_wr & ~te_rise & ~sbk_wr1;

  always @(posedge sys_clk) begin
    if (reset) begin
      tx_buffer_empty_flag <= 1'b1;
      tc   <= 1'b1;
    end else begin
      tx_buffer_empty_flag <= tx_move | (tx_buffer_empty_flag & ~clr_tx_buffer_empty_flag);
      tc   <= tc_set | (tc & ~clr_tc);
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // status has no write path at all, so writes there are lost
  always @(posedge sys_clk) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_go) begin
      case (avs_address)
        `SSFL_OFS_STATUS:  avs_readdata <= {24'h000000, flags};
        `SSFL_OFS_DATA:    avs_readdata <= {23'h000000, rx_buf};
        `SSFL_OFS_CONTROL: avs_readdata <= {24'h000000, ctrl};
        `SSFL_OFS_DIVISOR: avs_readdata <= {19'h00000, divisor};
        default:           avs_readdata <= 32'h00000000;
      endcase
    end
  end

endmodule // ssfl_top

// File: rtl/ssfl_tx.v
// transmit shifter: sends a data frame, an all-ones preamble or an all-zeros break
`timescale 1ns/100ps
`include "ssfl_defines.vh"
module ssfl_tx (
  input  wire       sys_clk,
  input  wire       reset,
  input  wire       tick,     // oversample tick, 16 per bit
  input  wire       start,    // take a new frame
  input  wire [1:0] kind,     // data, preamble or break
  input  wire [7:0] data,
  input  wire       char9,
  input  wire       par_en,
  input  wire       par_odd,
  output reg        txd,
  output reg        busy
);
  reg  [10:0] sh;     // frame, lsb first
  reg  [3:0]  left;   // bits still to send
  reg  [3:0]  phase;  // tick within bit
  wire        par = (char9 ? ^data : ^data[6:0]) ^ par_odd;
  wire [8:0]  body = char9 ? {par_en ? par : 1'b0, data} : {1'b1, par_en ? par : data[7], data[6:0]};
  // load on start, then one bit per 16 ticks
  always @(posedge sys_clk) begin
    if (reset) begin
      sh    <= 11'h7FF;
      left  <= 4'h0;
      phase <= 4'h0;
      txd   <= 1'b1;
      busy  <= 1'b0;
    end else if (start && !busy) begin
      case (kind)
        `SSFL_KIND_PRE: sh <= 11'h7FF;
        `SSFL_KIND_BRK: sh <= 11'h000;
        default:        sh <= {1'b1, body, 1'b0};
      endcase
      txd   <= (kind == `SSFL_KIND_PRE);
      left  <= char9 ? `SSFL_BITS_LONG : `SSFL_BITS_SHORT;
      phase <= 4'h0;
      busy  <= 1'b1;
    end else if (busy && tick) begin
      phase <= phase + 4'h1;
      if (phase == 4'hF) begin
        sh   <= {1'b1, sh[10:1]};
        left <= left - 4'h1;
        // line returns high after the last bit, also after a break
        txd  <= (left == 4'h1) ? 1'b1 : sh[1];
        busy <= (left != 4'h1);
      end
    end
  end
endmodule // ssfl_tx

// File: tb/ssfl_chk.sv
// bus handshake and status flag assertions for the serial status block
`timescale 1ns/100ps
`include "ssfl_defines.vh"
module ssfl_chk (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        rxd,
  input wire logic        txd
);
  logic seen; // an access has finished since reset
  // only the very first finished access can still see the reset value
  always @(posedge sys_clk) begin
    if (reset) seen <= 1'b0;
    else if (!avs_waitrequest) seen <= 1'b1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // request taken while the slave still waits
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  // status read finishing at this edge
  sequence s_st; avs_read && !avs_waitrequest && avs_address == `SSFL_OFS_STATUS; endsequence
  wait_answer_a: assert property (s_req |=> !avs_waitrequest) else $error("request left waiting");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
  read_hold_a: assert property (!avs_read |=> $stable(avs_readdata)) else $error("read data moved");
  reset_status_a: assert property (s_st ##0 !seen |-> avs_readdata[7:0] == `SSFL_STATUS_RESET)
    else $error("status after reset wrong");
  tc_empty_a: assert property (s_st ##0 avs_readdata[6] |-> avs_readdata[7])
    else $error("complete without empty buffer");
  tc_line_a: assert property (s_st ##0 avs_readdata[6] |-> txd) else $error("complete while sending");
  err_full_a: assert property (s_st ##0 (|avs_readdata[2:0]) |-> avs_readdata[5])
    else $error("error flag without full");
  status_width_a: assert property (s_st |-> avs_readdata[31:8] == 24'h0)
    else $error("status upper bits set");
  unmapped_a: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // ssfl_chk

// File: tb/ssfl_node.sv
// remote serial node: drives receive frames, decodes the transmit line
`timescale 1ns/100ps
module ssfl_node #(parameter int BIT_CLKS = 16) (
  input  wire logic sys_clk,
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] got_byte; // last decoded character
  logic       got_ok;   // pulse per decoded character
  initial begin
    rxd = 1'b1;
    got_ok = 1'b0;
  end
  // start bit first, then lsb first; optional one-clock glitch mid bit 2
  task automatic send(input logic [9:0] bits, input logic glitch);
    for (int b = 0; b < 10; b++) begin
      for (int c = 0; c < BIT_CLKS; c++) begin
        @(posedge sys_clk);
        rxd <= bits[b] ^ (glitch && b == 2 && c == BIT_CLKS / 2);
      end
    end
    @(posedge sys_clk);
    rxd <= 1'b1; // idle high, even after a low stop bit
  endtask
  // mid-bit sampling; a break decodes as zero, a preamble is never seen
  always begin
    @(negedge txd);
    repeat (BIT_CLKS / 2) @(posedge sys_clk);
    for (int b = 0; b < 8; b++) begin
      repeat (BIT_CLKS) @(posedge sys_clk);
      got_byte[b] = txd;
    end
    repeat (BIT_CLKS) @(posedge sys_clk);
    got_ok = 1'b1;
    @(posedge sys_clk);
    got_ok = 1'b0;
  end
endmodule // ssfl_node

// File: tb/ssfl_top_tb.sv
// self-checking bench: registers, transmit path, receive errors, overrun, idle
`timescale 1ns/100ps
`include "ssfl_defines.vh"
module ssfl_top_tb;
  localparam int BC = 16;           // clocks per bit, divisor 0
  localparam logic [31:0] RX = 32'h0000_002F;
  logic        sys_clk;
  logic        reset;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rxd;
  logic        txd;
  int          err_total;
  int          checks_done;
  logic [63:0] exp_q[$];            // read notes: mask, value
  logic [7:0]  tx_q[$];             // characters due on the line
  logic [63:0] n;
  logic [7:0]  d;
  logic [9:0]  fr;
  logic [7:0]  errv[4] = '{8'h20, 8'h24, 8'h22, 8'h21};
  ssfl_top ssfl_top_i (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd(txd));
  ssfl_node #(.BIT_CLKS(BC)) ssfl_node_i (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));
  // compare under mask; unknown bits never match
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    checks_done++;
    if ((got & m) !== (exp & m)) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got & m, exp & m);
    end
  endtask
  task automatic cmp_tx(input logic [7:0] got, input logic [7:0] exp);
    cmp_reg({24'h0, got}, {24'h0, exp}, 32'h0000_00FF);
  endtask
  // one access; held until wait is seen low, then a free cycle
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] v);
    avs_address <= a;
    avs_writedata <= v;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e});
    acc(1'b0, a, 32'h0);
  endtask
  task automatic wait_bits(input int k);
    repeat (k * BC) @(posedge sys_clk);
  endtask
  // watchers take the oldest note as each result appears
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      n = exp_q.pop_front();
      cmp_reg(avs_readdata, n[31:0], n[63:32]);
    end
  end
  always @(posedge ssfl_node_i.got_ok) cmp_tx(ssfl_node_i.got_byte, tx_q.pop_front());
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // a hang ends the run as a failure
  initial begin
    #60000;
    err_total++;
    print_verdict();
  end
  initial begin
    reset = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_total = 0;
    checks_done = 0;
    void'($urandom(32));
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(`SSFL_OFS_STATUS, 32'hC0, 32'hFFFF_FFFF);
    acc(1'b1, `SSFL_OFS_STATUS, $urandom);
    rd(`SSFL_OFS_STATUS, 32'hC0, 32'hFFFF_FFFF);
    rd(4'h2, 32'h0, 32'hFFFF_FFFF);
    acc(1'b1, `SSFL_OFS_DIVISOR, 32'h0);
    $display("test registers done");
    acc(1'b1, `SSFL_OFS_CONTROL, 32'h08); // armed enable rise queues a preamble
    rd(`SSFL_OFS_STATUS, 32'h80, 32'hC0);
    d = 8'($urandom);
    tx_q.push_back(d);
    acc(1'b1, `SSFL_OFS_DATA, {24'h0, d});
    rd(`SSFL_OFS_STATUS, 32'h00, 32'h80);
    wait_bits(24);
    rd(`SSFL_OFS_STATUS, 32'hC0, 32'hC0);
    tx_q.push_back(8'h00);
    acc(1'b1, `SSFL_OFS_CONTROL, 32'h09); // one break, then stop asking
    acc(1'b1, `SSFL_OFS_CONTROL, 32'h08);
    rd(`SSFL_OFS_STATUS, 32'h00, 32'h40);
    wait_bits(14);
    cmp_reg(tx_q.size(), 32'h0, 32'hFF);
    $display("test transmit done");
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      acc(1'b1, `SSFL_OFS_CONTROL, k == 3 ? 32'h48 : 32'h08);
      fr = {k != 2, d, 1'b0};
      if (k == 3) fr[8] = ~^d[6:0]; // wrong even parity
      ssfl_node_i.send(fr, k == 1);
      wait_bits(2);
      rd(`SSFL_OFS_STATUS, {24'h0, errv[k]}, RX);
      rd(`SSFL_OFS_DATA, {23'h0, fr[9:1]}, k == 3 ? 32'h7F : 32'hFF);
      rd(`SSFL_OFS_STATUS, 32'h0, RX);
    end
    $display("test receive done");
    acc(1'b1, `SSFL_OFS_CONTROL, 32'h08);
    rd(`SSFL_OFS_STATUS, 32'h0, RX); // nothing armed
    d = 8'($urandom);
    ssfl_node_i.send({1'b1, d, 1'b0}, 1'b0);
    ssfl_node_i.send({1'b1, ~d, 1'b0}, 1'b0);
    wait_bits(2);
    rd(`SSFL_OFS_DATA, {24'h0, d}, 32'hFF);
    rd(`SSFL_OFS_STATUS, 32'h28, RX);
    rd(`SSFL_OFS_DATA, {24'h0, d}, 32'hFF);
    rd(`SSFL_OFS_STATUS, 32'h0, RX);
    wait_bits(12);
    rd(`SSFL_OFS_STATUS, 32'h10, 32'h10);
    rd(`SSFL_OFS_DATA, 32'h0, 32'h0);
    $display("test overrun done");
    for (int t = 0; t < 2; t++) begin
      acc(1'b1, `SSFL_OFS_CONTROL, t ? 32'h28 : 32'h08);
      ssfl_node_i.send(10'h3FE, 1'b0);
      wait_bits(3);
      rd(`SSFL_OFS_STATUS, t ? 32'h20 : 32'h30, 32'h30);
      wait_bits(9);
      rd(`SSFL_OFS_STATUS, 32'h30, 32'h30);
      rd(`SSFL_OFS_DATA, 32'hFF, 32'hFF);
      wait_bits(12);
      rd(`SSFL_OFS_STATUS, 32'h0, 32'h30);
    end
    $display("test idle done");
    print_verdict();
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
endmodule // ssfl_top_tb
bind ssfl_top ssfl_chk ssfl_chk_i (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd(txd));
